// >>> hw/accel_result_reporting_defs.vh
// Purpose: constants for the acceleration result reporting block
// Assumes: 250 MHz core clock, AXI4-Lite register access
// Notes: offsets are byte addresses
`ifndef ACCEL_RESULT_REPORTING_DEFS_VH
`define ACCEL_RESULT_REPORTING_DEFS_VH
`define CODE_CRITICAL 11'h7ff
`define CODE_BAD_AXIS 11'h7fe
`define CODE_OVERFLOW 11'h7fd
`define CODE_OVERRANGE 11'h7fc
`define CODE_MAX_POS 11'h7fb
`define CODE_ZERO 11'h400
`define CODE_MIN_NEG 11'h005
`define CODE_UNDERRANGE 11'h004
`define CODE_UNDERFLOW 11'h003
`define CODE_CLK_FAULT 11'h002
`define CODE_PARITY_FAULT 11'h001
`define CODE_RESERVED 11'h000
`define EC_NONE 2'h0
`define EC_BEHAVIORAL 2'h1
`define EC_CRITICAL 2'h2
`define EC_TRANSIENT 2'h3
`define XFER_PTR_WRITE 2'h0
`define XFER_PTR_READ 2'h1
`define XFER_DATA_WRITE 2'h2
`define XFER_DATA_READ 2'h3
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h4
`define ADDR_RESULT_X 4'h8
`define ADDR_RESULT_Y 4'hc
`define CTRL_CLEAR_EXC_BIT 0
`define CTRL_SELFTEST_BIT 1
`define STAT_INIT_BIT 0
`define STAT_RESET_BIT 1
`define STAT_PHASE1_BIT 2
`define STAT_EC_LSB 4
`define PHASE1_US 800
`define PHASE2_END_US 3000
`define CLK_MHZ 250
`define PHASE1_CYCLES (`PHASE1_US * `CLK_MHZ)
`define PHASE2_END_CYCLES (`PHASE2_END_US * `CLK_MHZ)
`endif

// >>> hw/accel_result_reporting.v
// Purpose: map filter results to 11-bit words, freeze, reset and init
// Assumes: filter results arrive as signed values with a valid strobe
// Notes: serial framing lives outside; this block supplies words and class
// Function
// RULE1: top codes mark critical exception and bad axis
// RULE2: overflow gives 7fd, over-range gives 7fc
// RULE3: in-range words span 005 to 7fb
// RULE4: low codes mark under-range, underflow, faults
// RULE5: over-range is beyond scale, within datapath
// RULE6: filter output at sinc limit is overflow, clipped
// RULE7: negative side mirrors positive range checks
// RULE8: exception class encoded none, behavioral, critical, transient
// RULE9: host uses four register transfer types
// RULE10: freeze high blocks buffer updates
// RULE11: filter keeps running while frozen
// RULE12: frozen reads return last results before freeze
// RULE13: reset held until all supplies good
// RULE14: init reads fuses, powers down, waits reference
// RULE15: serial accesses ignored during phase one
// RULE16: phase two answers acceleration reads with non-data
// RULE17: phase one 800 us, phase two ends 3 ms
// RULE18: init pending set until phase two ends
// RULE19: clear-exceptions write clears reset flag
// RULE20: after clear, any access order accepted
// RULE21: only control register accepts writes
// RULE22: self-test or freeze flags behavioral exception
// RULE23: oscillator fault drives serial out high
// RULE24: unfrozen buffers refresh on each new result
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`include "accel_result_reporting_defs.vh"
module accel_result_reporting #(
  parameter DW = 16,
  parameter FULL_SCALE = 16'sd1019,
  parameter SINC_MAX = 16'sd8000,
  parameter FUSE_WORDS = 4,
  parameter PHASE1_CYC = `PHASE1_CYCLES,
  parameter PHASE2_CYC = `PHASE2_END_CYCLES
) (
  input wire i_clk,
  input wire i_rst,
  input wire [2:0] i_supply_good,
  input wire i_sample_freeze,
  input wire i_filt_valid,
  input wire [DW-1:0] i_filt_x,
  input wire [DW-1:0] i_filt_y,
  input wire [7:0] i_fuse_data,
  input wire i_osc_fault,
  input wire i_cs_n,
  input wire i_sclk,
  input wire i_sdo_data,
  input wire i_clk_fault,
  input wire i_parity_fault,
  input wire [1:0] i_axis_sel,
  output reg [10:0] o_accel_word,
  output reg [1:0] o_exception_class,
  output wire o_serial_enable,
  output reg o_sdo,
  output reg [FUSE_WORDS*8-1:0] o_fuse_mirror,
  output reg o_fuse_power,
  output reg o_ref_ready,
  output reg o_int_rst,
  input wire [31:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [31:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);
  localparam ST_RESET = 4'h1;
  localparam ST_PHASE1 = 4'h2;
  localparam ST_PHASE2 = 4'h4;
  localparam ST_RUN = 4'h8;

  // ***************************************
  // input synchronisers
  // ***************************************
  reg [2:0] sup_m, sup_s;
  reg frz_m, frz_s, cs_m, cs_s, sck_m, sck_s, osc_m, osc_s;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sup_m <= 3'h0;
      sup_s <= 3'h0;
      frz_m <= 1'b0;
      frz_s <= 1'b0;
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      osc_m <= 1'b0;
      osc_s <= 1'b0;
    end else begin
      sup_m <= i_supply_good;
      sup_s <= sup_m;
      frz_m <= i_sample_freeze;
      frz_s <= frz_m;
      cs_m <= i_cs_n;
      cs_s <= cs_m;
      sck_m <= i_sclk;
      sck_s <= sck_m;
      osc_m <= i_osc_fault;
      osc_s <= osc_m;
    end
  end

  // ***************************************
  // result coding
  // ***************************************
  function [10:0] code_word;
    input [DW-1:0] v;
    reg signed [DW-1:0] s;
    begin
      s = v;
      if (s >= SINC_MAX)
        code_word = `CODE_OVERFLOW; // RULE2 RULE6
      else if (s <= -SINC_MAX)
        code_word = `CODE_UNDERFLOW; // RULE4 RULE7
      else if (s > FULL_SCALE)
        code_word = `CODE_OVERRANGE; // RULE2 RULE5
      else if (s < -FULL_SCALE)
        code_word = `CODE_UNDERRANGE; // RULE4 RULE7
      else
        code_word = `CODE_ZERO + s[10:0]; // RULE3
    end
  endfunction

  // ***************************************
  // reset and initialization sequencer
  // ***************************************
  reg [3:0] state;
  reg [31:0] init_cnt;
  reg [7:0] fuse_idx;
  reg init_pending_flag;
  reg reset_occurred_flag;
  reg clear_req;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= ST_RESET;
      init_cnt <= 32'h0;
      fuse_idx <= 8'h0;
      o_fuse_mirror <= {FUSE_WORDS*8{1'b0}};
      o_fuse_power <= 1'b0;
      o_ref_ready <= 1'b0;
      o_int_rst <= 1'b1;
      init_pending_flag <= 1'b1;
      reset_occurred_flag <= 1'b1;
    end else begin
      if (state != ST_RESET)
        init_cnt <= init_cnt + 32'h1;
      case (state)
        ST_RESET: begin
          if (&sup_s) begin // RULE13
            o_int_rst <= 1'b0;
            o_fuse_power <= 1'b1;
            state <= ST_PHASE1;
          end
        end
        ST_PHASE1: begin
          if (fuse_idx < FUSE_WORDS) begin // RULE14
            o_fuse_mirror[fuse_idx*8 +: 8] <= i_fuse_data;
            fuse_idx <= fuse_idx + 8'h1;
          end else
            o_fuse_power <= 1'b0; // RULE14
          if (init_cnt >= PHASE1_CYC - 1) begin // RULE17
            o_fuse_power <= 1'b0;
            state <= ST_PHASE2;
          end
        end
        ST_PHASE2: begin
          if (init_cnt >= PHASE2_CYC - 1) begin // RULE17
            o_ref_ready <= 1'b1; // RULE14
            init_pending_flag <= 1'b0; // RULE18
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (clear_req)
            reset_occurred_flag <= 1'b0; // RULE19
        end
        default: state <= ST_RESET;
      endcase
    end
  end
  wire in_phase1 = (state == ST_PHASE1) | (state == ST_RESET);
  assign o_serial_enable = ~in_phase1; // RULE15

  // ***************************************
  // freeze and output buffers
  // ***************************************
  reg [10:0] buf_x, buf_y;
  reg selftest;
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      buf_x <= `CODE_ZERO;
      buf_y <= `CODE_ZERO;
    end else if (i_filt_valid && !frz_s) begin // RULE10 RULE11 RULE24
      buf_x <= code_word(i_filt_x);
      buf_y <= code_word(i_filt_y);
    end
  end

  wire behav = selftest | frz_s; // RULE22
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_accel_word <= `CODE_CRITICAL;
      o_exception_class <= `EC_CRITICAL;
      o_sdo <= 1'b0;
    end else begin
      if (reset_occurred_flag || state != ST_RUN)
        o_exception_class <= `EC_CRITICAL; // RULE8
      else if (i_clk_fault || i_parity_fault)
        o_exception_class <= `EC_TRANSIENT; // RULE8
      else if (behav)
        o_exception_class <= `EC_BEHAVIORAL; // RULE8 RULE22
      else
        o_exception_class <= `EC_NONE; // RULE8
      if (state != ST_RUN || reset_occurred_flag)
        o_accel_word <= `CODE_CRITICAL; // RULE1 RULE16
      else if (i_clk_fault)
        o_accel_word <= `CODE_CLK_FAULT; // RULE4
      else if (i_parity_fault)
        o_accel_word <= `CODE_PARITY_FAULT; // RULE4
      else if (i_axis_sel == 2'h0)
        o_accel_word <= buf_x; // RULE12 RULE20
      else if (i_axis_sel == 2'h1)
        o_accel_word <= buf_y; // RULE12
      else
        o_accel_word <= `CODE_BAD_AXIS; // RULE1
      if (osc_s && !cs_s)
        o_sdo <= 1'b1; // RULE23
      else
        // pin stays low in phase one unless an oscillator fault is seen with chip select low
        o_sdo <= i_sdo_data & sck_s & ~cs_s & ~in_phase1; // RULE15
    end
  end

  // ***************************************
  // register decode and read-back
  // ***************************************
  // only the low word offsets map; anything above is unmapped
  function reg_hit;
    input [31:0] a;
    input [3:0] off;
    begin
      reg_hit = (a[31:4] == 28'h0) && (a[3:0] == off);
    end
  endfunction

  // acceleration words read back as critical until the run state
  function [31:0] result_read;
    input run;
    input [10:0] b;
    begin
      if (run)
        result_read = {21'h0, b};
      else
        result_read = {21'h0, `CODE_CRITICAL}; // RULE16
    end
  endfunction

  // ***************************************
  // AXI4-Lite register slave
  // ***************************************
  reg aw_held, w_held;
  reg [31:0] aw_addr, w_data;
  reg [3:0] w_strb;
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  wire aw_now = aw_held | (s_axi_awvalid & s_axi_awready);
  wire w_now = w_held | (s_axi_wvalid & s_axi_wready);
  wire [31:0] wa = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wd = w_held ? w_data : s_axi_wdata;
  wire [3:0] ws = w_held ? w_strb : s_axi_wstrb;
  wire do_write = aw_now & w_now & ~s_axi_bvalid; // RULE9

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      selftest <= 1'b0;
      clear_req <= 1'b0;
    end else begin
      clear_req <= 1'b0;
      if (s_axi_awvalid & s_axi_awready & ~do_write) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready & ~do_write) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= 2'h0;
        // writes elsewhere are dropped with an OKAY answer
        if (!in_phase1 && reg_hit(wa, `ADDR_CTRL) && ws[0]) begin // RULE21
          selftest <= wd[`CTRL_SELFTEST_BIT];
          clear_req <= wd[`CTRL_CLEAR_EXC_BIT]; // RULE19
        end
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin // RULE9
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'h0;
      if (reg_hit(s_axi_araddr, `ADDR_CTRL))
        s_axi_rdata <= {30'h0, selftest, 1'b0};
      else if (reg_hit(s_axi_araddr, `ADDR_STATUS))
        s_axi_rdata <= {26'h0, o_exception_class, 1'b0,
          in_phase1, reset_occurred_flag, init_pending_flag}; // RULE18
      else if (reg_hit(s_axi_araddr, `ADDR_RESULT_X))
        s_axi_rdata <= result_read(state == ST_RUN, buf_x); // RULE12
      else if (reg_hit(s_axi_araddr, `ADDR_RESULT_Y))
        s_axi_rdata <= result_read(state == ST_RUN, buf_y);
      else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= 2'h2;
      end
    end else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// >>> tb/accel_result_reporting_chk.sv
// Purpose: port checks for accel_result_reporting
// Assumes: one clock, async active-high reset
// Notes: bound below the module
`timescale 1ns/10ps
module accel_result_reporting_chk (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_supply_good,
  input wire logic i_sample_freeze,
  input wire logic i_osc_fault,
  input wire logic i_cs_n,
  input wire logic [1:0] i_axis_sel,
  input wire logic i_clk_fault,
  input wire logic i_parity_fault,
  input wire logic [10:0] o_accel_word,
  input wire logic [1:0] o_exception_class,
  input wire logic o_serial_enable,
  input wire logic o_sdo,
  input wire logic o_fuse_power,
  input wire logic o_ref_ready,
  input wire logic o_int_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp
);
  // ********
  // checks
  // ********
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_rst; o_int_rst && !(&i_supply_good) |=> o_int_rst; endproperty
  a_rst: assert property (p_rst)
    else $error("reset released early");
  property p_quiet; o_fuse_power |-> !o_serial_enable; endproperty
  a_quiet: assert property (p_quiet)
    else $error("serial live in phase one");
  property p_iword; !o_ref_ready |-> o_accel_word == 11'h7ff; endproperty
  a_iword: assert property (p_iword)
    else $error("result during init");
  property p_icls; !o_ref_ready |-> o_exception_class == 2'h2; endproperty
  a_icls: assert property (p_icls)
    else $error("class not critical in init");
  property p_osc; (i_osc_fault && !i_cs_n) [*5] |-> o_sdo; endproperty
  a_osc: assert property (p_osc)
    else $error("data out not high on osc fault");
  property p_frz; i_sample_freeze [*5] |-> o_exception_class != 2'h0;
  endproperty
  a_frz: assert property (p_frz)
    else $error("freeze shows no exception");
  property p_axis; i_axis_sel[1] && !i_clk_fault && !i_parity_fault &&
    o_exception_class != 2'h2 |=> o_accel_word == 11'h7fe; endproperty
  a_axis: assert property (p_axis)
    else $error("bad axis code");
  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |=> s_axi_bvalid && s_axi_bresp == 2'h0; endproperty
  a_wr: assert property (p_wr)
    else $error("write response");
endmodule
bind accel_result_reporting accel_result_reporting_chk
  accel_result_reporting_chk_inst (.*);

// >>> tb/host_link.sv
// Purpose: host serial master model
// Assumes: link clock period 125 ns, idle low
// Notes: one frame per rising edge of i_go
`timescale 1ns/10ps
module host_link (
  input wire logic i_go,
  input wire logic [15:0] i_word,
  output logic o_cs_n,
  output logic o_sclk,
  output logic o_mosi
);
  // ********
  // frame
  // ********
  initial begin
    {o_cs_n, o_sclk, o_mosi} = 3'h4;
  end
  always @(posedge i_go) begin
    o_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = i_word[i];
      #62.5 o_sclk = 1'b1;
      #62.5 o_sclk = 1'b0;
    end
    o_cs_n = 1'b1;
    // released line must not keep the last bit
    o_mosi = ~o_mosi;
  end
endmodule

// >>> tb/tb.sv
// Purpose: self-checking bench for accel_result_reporting
// Assumes: init counts shortened to 20 and 60 cycles
// Notes: registers reached by AXI4-Lite tasks
`timescale 1ns/10ps
module tb;
  logic i_clk, i_rst, i_sample_freeze, i_filt_valid, i_osc_fault, go;
  logic i_clk_fault, i_parity_fault, i_cs_n, i_sclk, i_sdo_data;
  logic [2:0] i_supply_good;
  logic [15:0] i_filt_x, i_filt_y;
  logic [7:0] i_fuse_data;
  logic [1:0] i_axis_sel, o_exception_class, s_axi_bresp, s_axi_rresp;
  logic [10:0] o_accel_word;
  logic [31:0] o_fuse_mirror, s_axi_awaddr, s_axi_wdata, s_axi_araddr;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic o_serial_enable, o_sdo, o_fuse_power, o_ref_ready, o_int_rst;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [1:0] as[5] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0};
  logic [31:0] ex[5] = '{32'h464, 32'h39c, 32'h7fe, 32'h2, 32'h1};
  int bad_count, check_count, cyc, k, t0;
  int vals[7] = '{0, 1019, -1019, 1020, -1020, 8000, -8000};
  // ********
  // design, far side, clock
  // ********
  accel_result_reporting #(.PHASE1_CYC(20), .PHASE2_CYC(60))
    accel_result_reporting_inst (.*);
  host_link host_link_inst (.i_go(go), .i_word(16'h0400), .o_cs_n(i_cs_n),
    .o_sclk(i_sclk), .o_mosi(i_sdo_data));
  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string n, input [31:0] e, input [31:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic axw(input [31:0] a, input [31:0] d);
    logic done;
    @(posedge i_clk);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    done = 1'b0;
    while (!done) begin
      @(posedge i_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      done = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    chk("bresp", 32'h0, {30'h0, s_axi_bresp});
  endtask
  task automatic rchk(input [31:0] a, input [31:0] m, input [31:0] e);
    logic done;
    @(posedge i_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    done = 1'b0;
    while (!done) begin
      @(posedge i_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      done = s_axi_rvalid;
    end
    rd = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("reg", e, rd & m);
  endtask
  task automatic pulse(input int v);
    @(posedge i_clk);
    {i_filt_x, i_filt_y, i_filt_valid} <= {v[15:0], 16'(-v), 1'b1};
    @(posedge i_clk);
    i_filt_valid <= 1'b0;
  endtask
  function automatic [31:0] code(input int v);
    if (v >= 8000) return 32'h7fd;
    if (v > 1019) return 32'h7fc;
    if (v <= -8000) return 32'h3;
    if (v < -1019) return 32'h4;
    return 32'h400 + v;
  endfunction
  // ********
  // sequence
  // ********
  initial begin
    i_rst = 1'b1;
    {i_sample_freeze, i_filt_valid, i_osc_fault, i_clk_fault, go} = 5'h0;
    {i_parity_fault, i_supply_good, i_axis_sel, i_filt_x, i_filt_y} = '0;
    {i_fuse_data, s_axi_wstrb} = 12'h5af;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    s_axi_rready = 1'b0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    chk("int_rst", 32'h1, {31'h0, o_int_rst});
    i_supply_good <= 3'h7;
    while (!o_fuse_power) @(posedge i_clk);
    t0 = cyc;
    while (o_fuse_power) @(posedge i_clk);
    chk("fuse", 32'h5a5a5a5a, o_fuse_mirror);
    chk("ser_en", 32'h0, {31'h0, o_serial_enable});
    while (!o_serial_enable) @(posedge i_clk);
    chk("phase1", 32'd20, cyc - t0);
    t0 = cyc;
    rchk(32'h4, 32'h37, 32'h23);
    rchk(32'h8, 32'h7ff, 32'h7ff);
    while (!o_ref_ready) @(posedge i_clk);
    chk("phase2", 32'd40, cyc - t0);
    rchk(32'h4, 32'h37, 32'h22);
    axw(32'h0, 32'h1);
    rchk(32'h4, 32'h37, 32'h0);
    axw(32'h4, 32'hffffffff);
    rchk(32'h4, 32'h37, 32'h0);
    rchk(32'h10, 32'h0, 32'h0);
    chk("rresp", 32'h2, {30'h0, s_axi_rresp});
    for (k = 0; k < 7; k++) begin
      pulse(vals[k]);
      rchk(32'h8, 32'h7ff, code(vals[k]));
      rchk(32'hc, 32'h7ff, code(-vals[k]));
    end
    i_sample_freeze <= 1'b1;
    repeat (4) @(posedge i_clk);
    pulse(100);
    rchk(32'h8, 32'h7ff, 32'h3);
    rchk(32'h4, 32'h30, 32'h10);
    i_sample_freeze <= 1'b0;
    repeat (4) @(posedge i_clk);
    pulse(100);
    rchk(32'h8, 32'h7ff, code(100));
    for (k = 0; k < 5; k++) begin
      {i_axis_sel, i_clk_fault, i_parity_fault} <= {as[k], k == 3, k == 4};
      repeat (3) @(posedge i_clk);
      chk("word", ex[k], {21'h0, o_accel_word});
    end
    chk("class", 32'h3, {30'h0, o_exception_class});
    {i_clk_fault, i_parity_fault, i_osc_fault} <= 3'h1;
    @(posedge i_clk);
    go <= 1'b1;
    repeat (40) @(posedge i_clk);
    chk("sdo", 32'h1, {31'h0, o_sdo});
    go <= 1'b0;
    while (!i_cs_n) @(posedge i_clk);
    {i_osc_fault, i_rst} <= 2'h1;
    repeat (2) @(posedge i_clk);
    chk("rst_word", 32'h7ff, {21'h0, o_accel_word});
    i_rst <= 1'b0;
    repeat (5) @(posedge i_clk);
    chk("ser_en2", 32'h0, {31'h0, o_serial_enable});
    rchk(32'h4, 32'h3, 32'h3);
    complete_run();
  end
endmodule
